// File: timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register byte addresses on the APB window
`define ADDR_CTRL_ONE 8'h00
`define ADDR_CTRL_TWO 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_CAP1_HI 8'h0C
`define ADDR_CAP1_LO 8'h10
`define ADDR_CMP1_HI 8'h14
`define ADDR_CMP1_LO 8'h18
`define ADDR_CAP2_HI 8'h1C
`define ADDR_CAP2_LO 8'h20
`define ADDR_CMP2_HI 8'h24
`define ADDR_CMP2_LO 8'h28
`define ADDR_CNT_HI 8'h2C
`define ADDR_CNT_LO 8'h30

// Control one fields
`define C1_CAP_IRQ_EN 7
`define C1_CMP_IRQ_EN 6
`define C1_PULSE_ACTIVE 2
`define C1_TRIG_EDGE 1
`define C1_AFTER_PULSE 0

// Control two fields
`define C2_CMP1_PIN_EN 7
`define C2_CMP2_PIN_EN 6
`define C2_ONE_PULSE 5
`define C2_PWM 4
`define C2_CLK_SEL_HI 3
`define C2_CLK_SEL_LO 2
`define C2_CAP2_EDGE 1
`define C2_EXT_EDGE 0

// Status bit positions
`define ST_CAP1 7
`define ST_CMP1 6
`define ST_CAP2 4
`define ST_CMP2 3

// Flag vector indexes
`define F_CAP1 0
`define F_CMP1 1
`define F_CAP2 2
`define F_CMP2 3

// Values
`define CTRL_RESET 8'h00
`define CMP_RESET 16'h8000
`define CNT_RESET 16'hFFFC
`define CNT_RELOAD 16'hFFFC
`define CAP_ONE_PULSE 16'hFFFD
`define CAP_RESET 16'h0000
`define SEL_DIV4 2'b00
`define SEL_DIV2 2'b01
`define SEL_DIV8 2'b10
`define SEL_EXT 2'b11
`define DIV4_LAST 3'h3
`define DIV8_LAST 3'h7

`endif

// File: timer_pkg.sv
package timer_pkg;
   // Waveform mode, one-hot
   typedef enum logic [2:0] {
      MODE_CMP = 3'b001,
      MODE_OPM = 3'b010,
      MODE_PWM = 3'b100
   } mode_t;
endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; a level counts once stages two and three agree
module pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic s1_q, s2_q, s3_q, lvl_q;
   logic stable;

   // Only s2 reads s1, keeping metastability out of the edge logic
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign stable = (s2_q == s3_q);

   // Accepted level follows only agreed samples
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_q <= 1'b0;
      end else if (stable) begin
         lvl_q <= s2_q;
      end
   end

   assign rise = stable & s2_q & ~lvl_q;
   assign fall = stable & ~s2_q & lvl_q;
endmodule

// File: timer_tick.sv
`timescale 1ns/10ps
`include "timer_defines.svh"
// Timer tick enable: CPU clock divided, or edges of the external pin
module timer_tick (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] sel,
   input wire logic ext_rising,
   input wire logic ext_pin,
   input wire logic run,
   output logic tick
);
   logic [2:0] div_q;
   logic ext_rise, ext_fall, raw;

   // Free-running divider, stopped work is gated at the output only
   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   pin_sync u_ext (
      .clk(clk),
      .rst(rst),
      .pin(ext_pin),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // Tick select per clock select field
   always_comb begin
      case (sel)
         `SEL_DIV4: raw = (div_q[1:0] == `DIV4_LAST);
         `SEL_DIV2: raw = div_q[0];
         `SEL_DIV8: raw = (div_q == `DIV8_LAST);
         `SEL_EXT: raw = ext_rising ? ext_rise : ext_fall;
         default: raw = 1'b0;
      endcase
   end

   assign tick = raw & run;
endmodule

// File: timer_pwm.sv
`timescale 1ns/10ps
`include "timer_defines.svh"
module timer_pwm
   import timer_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CAP1_IN,
   input wire logic CAP2_IN,
   input wire logic EXT_CLK_IN,
   output logic COMP1_OUT,
   output logic COMP1_OE,
   output logic COMP2_OUT,
   output logic COMP2_OE,
   input wire logic IRQ_MASK,
   input wire logic WAIT_MODE,
   input wire logic HALT_MODE,
   input wire logic WAKE_INT,
   output logic TIMER_IRQ,
   output logic WAKE_REQ
);
   logic [7:0] ctrl1_q, ctrl2_q;
   logic [15:0] cnt_q, cap1_q, cap2_q, cmp1_q, cmp2_q, act1_q, act2_q, c1, c2;
   logic [3:0] flag_q, arm_q, fset, fclr;
   logic [1:0] cmp_en_q, cap_inh_q, halt_arm_q;
   logic [31:0] prdata_q;
   logic [31:0] prdata_q_d;
   logic out1_q, out2_q;
   mode_t mode;
   logic tick, m1, m2, trig, ev1, ev2, wake1, wake2;
   logic r1, f1, r2, f2, pend;
   logic setup, acc, wr, rd, hit;

   // Register decode shared by writes, read side effects and flag clears
   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   // Mode select; PWM wins over one-pulse
   always_comb begin
      if (ctrl2_q[`C2_PWM]) begin
         mode = MODE_PWM;
      end else if (ctrl2_q[`C2_ONE_PULSE]) begin
         mode = MODE_OPM;
      end else begin
         mode = MODE_CMP;
      end
   end

   timer_tick u_tick (
      .clk(CLK),
      .rst(RST),
      .sel(ctrl2_q[`C2_CLK_SEL_HI:`C2_CLK_SEL_LO]),
      .ext_rising(ctrl2_q[`C2_EXT_EDGE]),
      .ext_pin(EXT_CLK_IN),
      .run(~HALT_MODE),
      .tick(tick)
   );

   pin_sync u_cap1 (
      .clk(CLK),
      .rst(RST),
      .pin(CAP1_IN),
      .rise(r1),
      .fall(f1)
   );

   pin_sync u_cap2 (
      .clk(CLK),
      .rst(RST),
      .pin(CAP2_IN),
      .rise(r2),
      .fall(f2)
   );

   // Qualified edges; in PWM pin one is ignored entirely
   assign ev1 = (ctrl1_q[`C1_TRIG_EDGE] ? r1 : f1) & (mode != MODE_PWM);
   assign ev2 = ctrl2_q[`C2_CAP2_EDGE] ? r2 : f2;
   assign trig = ev1 & (mode == MODE_OPM) & ~HALT_MODE;
   assign wake1 = WAKE_INT & halt_arm_q[0];
   assign wake2 = WAKE_INT & halt_arm_q[1];

   // PWM compares on the buffered copies, other modes on the live values
   assign c1 = (mode == MODE_PWM) ? act1_q : cmp1_q;
   assign c2 = (mode == MODE_PWM) ? act2_q : cmp2_q;
   // Match acts on the tick leaving the count, giving value plus five ticks
   assign m1 = tick & (cnt_q == c1) & cmp_en_q[0];
   assign m2 = tick & (cnt_q == c2) & cmp_en_q[1];

   // APB phases
   assign setup = PSEL & ~PENABLE;
   assign acc = PSEL & PENABLE;
   assign wr = acc & PWRITE & hit;
   assign rd = acc & ~PWRITE & hit;
   assign PREADY = 1'b1;
   assign PSLVERR = acc & ~hit;
   assign PRDATA = prdata_q;

   // Read mux sampled in the setup cycle
   always_comb begin
      hit = 1'b1;
      case (PADDR)
         `ADDR_CTRL_ONE: prdata_q_d = {24'h00_0000, ctrl1_q};
         `ADDR_CTRL_TWO: prdata_q_d = {24'h00_0000, ctrl2_q};
         `ADDR_STATUS: prdata_q_d = {24'h00_0000, flag_q[`F_CAP1], flag_q[`F_CMP1], 1'b0,
            flag_q[`F_CAP2], flag_q[`F_CMP2], 3'h0};
         `ADDR_CAP1_HI: prdata_q_d = {24'h00_0000, cap1_q[15:8]};
         `ADDR_CAP1_LO: prdata_q_d = {24'h00_0000, cap1_q[7:0]};
         `ADDR_CMP1_HI: prdata_q_d = {24'h00_0000, cmp1_q[15:8]};
         `ADDR_CMP1_LO: prdata_q_d = {24'h00_0000, cmp1_q[7:0]};
         `ADDR_CAP2_HI: prdata_q_d = {24'h00_0000, cap2_q[15:8]};
         `ADDR_CAP2_LO: prdata_q_d = {24'h00_0000, cap2_q[7:0]};
         `ADDR_CMP2_HI: prdata_q_d = {24'h00_0000, cmp2_q[15:8]};
         `ADDR_CMP2_LO: prdata_q_d = {24'h00_0000, cmp2_q[7:0]};
         `ADDR_CNT_HI: prdata_q_d = {24'h00_0000, cnt_q[15:8]};
         `ADDR_CNT_LO: prdata_q_d = {24'h00_0000, cnt_q[7:0]};
         default: begin
            prdata_q_d = 32'h0000_0000;
            hit = 1'b0;
         end
      endcase
   end

   // Read data held from setup so it stays stable through the access
   always_ff @(posedge CLK) begin
      if (RST) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= prdata_q_d;
      end
   end

   // Control registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl1_q <= `CTRL_RESET;
         ctrl2_q <= `CTRL_RESET;
      end else if (wr) begin
         if (is_reg(PADDR, `ADDR_CTRL_ONE)) begin
            ctrl1_q <= PWDATA[7:0];
         end
         if (is_reg(PADDR, `ADDR_CTRL_TWO)) begin
            ctrl2_q <= PWDATA[7:0];
         end
      end
   end

   // Compare registers and their high-byte inhibit
   always_ff @(posedge CLK) begin
      if (RST) begin
         cmp1_q <= `CMP_RESET;
         cmp2_q <= `CMP_RESET;
         cmp_en_q <= 2'h3;
      end else if (wr) begin
         if (is_reg(PADDR, `ADDR_CMP1_HI)) begin
            cmp1_q[15:8] <= PWDATA[7:0];
            cmp_en_q[0] <= 1'b0;
         end
         if (is_reg(PADDR, `ADDR_CMP1_LO)) begin
            cmp1_q[7:0] <= PWDATA[7:0];
            cmp_en_q[0] <= 1'b1;
         end
         if (is_reg(PADDR, `ADDR_CMP2_HI)) begin
            cmp2_q[15:8] <= PWDATA[7:0];
            cmp_en_q[1] <= 1'b0;
         end
         if (is_reg(PADDR, `ADDR_CMP2_LO)) begin
            cmp2_q[7:0] <= PWDATA[7:0];
            cmp_en_q[1] <= 1'b1;
         end
      end
   end

   // Buffered copies track live values outside PWM, load at period end in PWM
   always_ff @(posedge CLK) begin
      if (RST) begin
         act1_q <= `CMP_RESET;
         act2_q <= `CMP_RESET;
      end else if (mode != MODE_PWM || m2) begin
         act1_q <= cmp1_q;
         act2_q <= cmp2_q;
      end
   end

   // Counter reloaded by the one-pulse trigger and the PWM period end, else counts ticks; halt removes the ticks and blocks the trigger
   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt_q <= `CNT_RESET;
      end else if (trig) begin
         cnt_q <= `CNT_RELOAD;
      end else if (m2 && mode == MODE_PWM) begin
         cnt_q <= `CNT_RELOAD;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Capture inhibit after a high-byte read, so the pair is read coherently
   always_ff @(posedge CLK) begin
      if (RST) begin
         cap_inh_q <= 2'h0;
      end else if (rd) begin
         if (is_reg(PADDR, `ADDR_CAP1_HI)) cap_inh_q[0] <= 1'b1;
         if (is_reg(PADDR, `ADDR_CAP1_LO)) cap_inh_q[0] <= 1'b0;
         if (is_reg(PADDR, `ADDR_CAP2_HI)) cap_inh_q[1] <= 1'b1;
         if (is_reg(PADDR, `ADDR_CAP2_LO)) cap_inh_q[1] <= 1'b0;
      end
   end

   // Pin two edges, and pin one edges in compare mode, seen during halt are held until the wake-up
   always_ff @(posedge CLK) begin
      if (RST) begin
         halt_arm_q <= 2'h0;
      end else if (HALT_MODE) begin
         if (ev1 && mode == MODE_CMP) halt_arm_q[0] <= 1'b1;
         if (ev2) halt_arm_q[1] <= 1'b1;
      end else begin
         halt_arm_q <= 2'h0;
      end
   end

   // Capture registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         cap1_q <= `CAP_RESET;
         cap2_q <= `CAP_RESET;
      end else begin
         if (trig) begin
            cap1_q <= `CAP_ONE_PULSE;
         end else if (wake1 || (ev1 && mode == MODE_CMP && !HALT_MODE && !cap_inh_q[0])) begin
            cap1_q <= cnt_q;
         end
         if (wake2 || (ev2 && !HALT_MODE && !cap_inh_q[1])) begin
            cap2_q <= cnt_q;
         end
      end
   end

   // Flag set terms per mode
   always_comb begin
      fset = 4'h0;
      fset[`F_CAP2] = (ev2 & ~HALT_MODE & ~cap_inh_q[1]) | wake2;
      fset[`F_CAP1] = wake1 | trig;
      case (mode)
         MODE_CMP: begin
            fset[`F_CAP1] = wake1 | (ev1 & ~HALT_MODE & ~cap_inh_q[0]);
            fset[`F_CMP1] = m1;
            fset[`F_CMP2] = m2;
         end
         MODE_OPM: fset[`F_CMP2] = m2;
         MODE_PWM: fset[`F_CAP1] = m2;
         default: fset = 4'h0;
      endcase
   end

   // Second step of the clear: access to the matching low byte
   always_comb begin
      fclr = 4'h0;
      fclr[`F_CAP1] = acc & is_reg(PADDR, `ADDR_CAP1_LO);
      fclr[`F_CMP1] = acc & is_reg(PADDR, `ADDR_CMP1_LO);
      fclr[`F_CAP2] = acc & is_reg(PADDR, `ADDR_CAP2_LO);
      fclr[`F_CMP2] = acc & is_reg(PADDR, `ADDR_CMP2_LO);
      fclr = fclr & arm_q;
   end

   // Status read arms only the flags it showed as set; set beats clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         flag_q <= 4'h0;
         arm_q <= 4'h0;
      end else begin
         flag_q <= fset | (flag_q & ~fclr);
         if (rd && is_reg(PADDR, `ADDR_STATUS)) begin
            arm_q <= arm_q | {prdata_q[`ST_CMP2], prdata_q[`ST_CAP2],
               prdata_q[`ST_CMP1], prdata_q[`ST_CAP1]};
         end else begin
            arm_q <= arm_q & ~fclr;
         end
      end
   end

   // Pin one level: pulse start, pulse end and periodic restart
   always_ff @(posedge CLK) begin
      if (RST) begin
         out1_q <= 1'b0;
      end else begin
         case (mode)
            MODE_OPM: begin
               if (trig) out1_q <= ctrl1_q[`C1_PULSE_ACTIVE];
               else if (m1) out1_q <= ctrl1_q[`C1_AFTER_PULSE];
            end
            MODE_PWM: begin
               if (m2) out1_q <= ctrl1_q[`C1_PULSE_ACTIVE];
               else if (m1) out1_q <= ctrl1_q[`C1_AFTER_PULSE];
            end
            MODE_CMP: begin
               if (m1) out1_q <= ctrl1_q[`C1_AFTER_PULSE];
            end
            default: out1_q <= 1'b0;
         endcase
      end
   end

   // Pin two waveform exists only in plain compare operation
   always_ff @(posedge CLK) begin
      if (RST) begin
         out2_q <= 1'b0;
      end else if (m2 && mode == MODE_CMP) begin
         out2_q <= ctrl1_q[`C1_PULSE_ACTIVE];
      end
   end

   assign COMP1_OUT = out1_q;
   assign COMP1_OE = ctrl2_q[`C2_CMP1_PIN_EN];
   assign COMP2_OUT = out2_q;
   assign COMP2_OE = ctrl2_q[`C2_CMP2_PIN_EN] & (mode == MODE_CMP);

   // Request pending; wait state does not stop anything here
   assign pend = (ctrl1_q[`C1_CAP_IRQ_EN] & (flag_q[`F_CAP1] | flag_q[`F_CAP2]))
      | (ctrl1_q[`C1_CMP_IRQ_EN] & (flag_q[`F_CMP1] | flag_q[`F_CMP2]));
   assign TIMER_IRQ = pend & ~IRQ_MASK;
   assign WAKE_REQ = pend & WAIT_MODE;

   opm_load_a: assert property (@(posedge CLK) disable iff (RST)
      trig |=> cnt_q == `CNT_RELOAD && cap1_q == `CAP_ONE_PULSE && flag_q[`F_CAP1])
      else $error("one-pulse trigger load wrong");
   opm_level_a: assert property (@(posedge CLK) disable iff (RST)
      trig |=> out1_q == $past(ctrl1_q[`C1_PULSE_ACTIVE]))
      else $error("pulse level not driven");
   opm_end_a: assert property (@(posedge CLK) disable iff (RST)
      (mode == MODE_OPM && m1 && !trig) |=> out1_q == $past(ctrl1_q[`C1_AFTER_PULSE]))
      else $error("pulse did not end");
   pwm_reload_a: assert property (@(posedge CLK) disable iff (RST)
      (mode == MODE_PWM && m2) |=> cnt_q == `CNT_RELOAD && flag_q[`F_CAP1])
      else $error("period restart wrong");
   pwm_noflag_a: assert property (@(posedge CLK) disable iff (RST)
      mode == MODE_PWM |-> !fset[`F_CMP1] && !fset[`F_CMP2])
      else $error("compare flag set in PWM");
   opm_noflag_a: assert property (@(posedge CLK) disable iff (RST)
      mode == MODE_OPM |-> !fset[`F_CMP1])
      else $error("compare one flag set in one-pulse");
   flag_clear_a: assert property (@(posedge CLK) disable iff (RST)
      (fclr[`F_CAP1] && !fset[`F_CAP1]) |=> !flag_q[`F_CAP1])
      else $error("capture flag not cleared");
   halt_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (HALT_MODE && $past(HALT_MODE)) |-> $stable(cnt_q))
      else $error("counter moved in halt");
   cmp_inhibit_a: assert property (@(posedge CLK) disable iff (RST)
      !cmp_en_q[0] |-> !m1)
      else $error("inhibited compare matched");
endmodule

// File: pin_source.sv
`timescale 1ns/10ps
// Far side of the timer pins: capture sources and an external clock
module pin_source (
   input wire logic clk,
   output logic cap1_pin,
   output logic cap2_pin,
   output logic ext_pin
);
   logic [3:0] div_q;
   initial begin
      div_q = 4'h0;
      cap1_pin = 1'b0;
      cap2_pin = 1'b0;
      ext_pin = 1'b0;
   end
   // External clock of twelve CPU cycles; free running like a crystal would
   always @(posedge clk) begin
      div_q <= (div_q == 4'h5) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'h5)
         ext_pin <= ~ext_pin;
   end
   // Pin levels change only just after a CPU edge
   task automatic drive(input int which, input logic v);
      @(posedge clk);
      if (which == 1)
         cap1_pin <= v;
      else
         cap2_pin <= v;
   endtask
endmodule

// File: timer_pwm_tb_top.sv
`timescale 1ns/10ps
`include "timer_defines.svh"
// Random and corner-case bench for the pulse and PWM modes
module timer_pwm_tb_top;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, CAP1_IN, CAP2_IN, EXT_CLK_IN;
   logic COMP1_OUT, COMP1_OE, COMP2_OUT, COMP2_OE, TIMER_IRQ, WAKE_REQ;
   logic IRQ_MASK = 1'b0, WAIT_MODE = 1'b0, HALT_MODE = 1'b0, WAKE_INT = 1'b0;
   logic [7:0] rd_q, hold;
   logic err_q;
   logic [31:0] seed = 32'd40;
   int err_total = 0, num_checks = 0;
   int a, b, n, cyc;
   int dv[4] = '{4, 2, 8, 12};

   always #5 CLK = ~CLK;

   timer_pwm dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CAP1_IN(CAP1_IN), .CAP2_IN(CAP2_IN),
      .EXT_CLK_IN(EXT_CLK_IN), .COMP1_OUT(COMP1_OUT), .COMP1_OE(COMP1_OE),
      .COMP2_OUT(COMP2_OUT), .COMP2_OE(COMP2_OE), .IRQ_MASK(IRQ_MASK),
      .WAIT_MODE(WAIT_MODE), .HALT_MODE(HALT_MODE), .WAKE_INT(WAKE_INT),
      .TIMER_IRQ(TIMER_IRQ), .WAKE_REQ(WAKE_REQ));
   pin_source src_u (.clk(CLK), .cap1_pin(CAP1_IN), .cap2_pin(CAP2_IN),
      .ext_pin(EXT_CLK_IN));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Timer ticks covered by a cycle count; rounds up since tick phase is free
   function automatic logic [7:0] ticks(input int c, input int d);
      return 8'((c + d - 1) / d);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One APB transfer, held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= {24'h00_0000, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Wait states are waited out; only the watchdog ends a stuck slave
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd_q = PRDATA[7:0];
      err_q = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   // Wait for pin one to reach a level, then count cycles it stays there
   task automatic measure(input logic lvl);
      int k;
      k = 0;
      while (COMP1_OUT !== lvl && k < 3000) begin
         @(posedge CLK);
         k++;
      end
      cyc = 0;
      while (COMP1_OUT === lvl && cyc < 3000) begin
         @(posedge CLK);
         cyc++;
      end
   endtask

   // Watchdog: the whole run needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge CLK);
      err_total++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      check(8'(COMP1_OE), 8'h00);
      apb(1'b0, `ADDR_CMP1_HI, 8'h00);
      check(rd_q, 8'h80);
      apb(1'b0, 8'h40, 8'h00);
      check(8'(err_q), 8'h01);
      // PWM with one-pulse also selected; random compare values
      seed = xs(seed);
      a = 20 + int'(seed % 8);
      seed = xs(seed);
      b = a + 8 + int'(seed % 16);
      apb(1'b1, `ADDR_CMP1_HI, 8'h00);
      apb(1'b1, `ADDR_CMP1_LO, 8'(a));
      apb(1'b1, `ADDR_CMP2_HI, 8'h00);
      apb(1'b1, `ADDR_CMP2_LO, 8'(b));
      apb(1'b1, `ADDR_CTRL_ONE, 8'h81);
      apb(1'b1, `ADDR_CTRL_TWO, 8'hF4);
      measure(1'b1);
      check(ticks(cyc, 2), 8'(b - a));
      measure(1'b0);
      check(ticks(cyc, 2), 8'(a + 5));
      measure(1'b1);
      check(ticks(cyc, 2), 8'(b - a));
      // New compare one written just after a period starts must wait for the next
      apb(1'b1, `ADDR_CMP1_HI, 8'h00);
      apb(1'b1, `ADDR_CMP1_LO, 8'(a + 4));
      measure(1'b1);
      check(ticks(cyc, 2), 8'(b - a));
      measure(1'b0);
      check(ticks(cyc, 2), 8'(a + 9));
      apb(1'b0, `ADDR_STATUS, 8'h00);
      check(rd_q & 8'hD8, 8'h80);
      check(8'(TIMER_IRQ), 8'h01);
      IRQ_MASK <= 1'b1;
      @(posedge CLK);
      check(8'(TIMER_IRQ), 8'h00);
      IRQ_MASK <= 1'b0;
      WAIT_MODE <= 1'b1;
      @(posedge CLK);
      @(posedge CLK);
      check(8'(WAKE_REQ), 8'h01);
      WAIT_MODE <= 1'b0;
      // Equal levels hold the pin still, which also parks it low
      apb(1'b1, `ADDR_CTRL_ONE, 8'h80);
      measure(1'b0);
      check(8'(cyc / 100), 8'd30);
      apb(1'b1, `ADDR_CMP2_LO, 8'hFF);
      apb(1'b1, `ADDR_CTRL_ONE, 8'h86);
      // One pulse per clock source, random lengths
      for (int s = 0; s < 4; s++) begin
         seed = xs(seed);
         n = 4 + int'(seed % 20);
         apb(1'b1, `ADDR_CMP1_HI, 8'h00);
         apb(1'b1, `ADDR_CMP1_LO, 8'(n));
         apb(1'b1, `ADDR_CTRL_TWO, 8'hE3 | 8'(s << 2));
         src_u.drive(2, 1'b1);
         src_u.drive(1, 1'b1);
         measure(1'b1);
         check(ticks(cyc, dv[s]), 8'(n + 5));
         check(8'(COMP2_OE), 8'h00);
         check(8'(COMP2_OUT), 8'h00);
         check(8'(COMP1_OE), 8'h01);
         apb(1'b0, `ADDR_STATUS, 8'h00);
         check(rd_q & 8'hD8, 8'h90);
         check(8'(TIMER_IRQ), 8'h01);
         apb(1'b0, `ADDR_CAP1_HI, 8'h00);
         check(rd_q, 8'hFF);
         apb(1'b0, `ADDR_CAP1_LO, 8'h00);
         check(rd_q, 8'hFD);
         apb(1'b0, `ADDR_CAP2_LO, 8'h00);
         apb(1'b0, `ADDR_STATUS, 8'h00);
         check(rd_q & 8'hD8, 8'h00);
         src_u.drive(1, 1'b0);
         src_u.drive(2, 1'b0);
      end
      // Halt freezes the count; leaving it lets the count move on
      HALT_MODE <= 1'b1;
      repeat (30) @(posedge CLK);
      apb(1'b0, `ADDR_CNT_LO, 8'h00);
      hold = rd_q;
      repeat (40) @(posedge CLK);
      apb(1'b0, `ADDR_CNT_LO, 8'h00);
      check(rd_q, hold);
      // A pin two edge in halt only arms; the wake-up captures the held count
      src_u.drive(2, 1'b1);
      repeat (6) @(posedge CLK);
      check(8'(TIMER_IRQ), 8'h00);
      WAKE_INT <= 1'b1;
      @(posedge CLK);
      WAKE_INT <= 1'b0;
      HALT_MODE <= 1'b0;
      repeat (40) @(posedge CLK);
      apb(1'b0, `ADDR_CNT_LO, 8'h00);
      check(8'(rd_q != hold), 8'h01);
      apb(1'b0, `ADDR_CAP2_LO, 8'h00);
      check(rd_q, hold);
      apb(1'b0, `ADDR_STATUS, 8'h00);
      check(rd_q & 8'hD8, 8'h10);
      // Reset out of halt restarts the count from its reset value
      HALT_MODE <= 1'b1;
      RST <= 1'b1;
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      HALT_MODE <= 1'b0;
      apb(1'b0, `ADDR_CNT_LO, 8'h00);
      check(rd_q, 8'hFC);
      check(8'(COMP1_OE), 8'h00);
      conclude();
   end
endmodule
